/* File: tsber_pkg.sv */
package tsber_pkg;

    // Reference packet: four header bytes, then an all-zero payload
    localparam logic [7:0] REF_SYNC        = 8'h47;
    localparam logic [7:0] REF_HDR1        = 8'h1f;
    localparam logic [7:0] REF_HDR2        = 8'hff;
    localparam logic [7:0] REF_HDR3        = 8'h10;
    localparam logic [7:0] REF_PAYLOAD     = 8'h00;
    localparam int         PKT_HDR_LEN     = 4;
    localparam int         PKT_PAYLOAD_LEN = 184;
    localparam int         PKT_LEN         = PKT_HDR_LEN + PKT_PAYLOAD_LEN;

    // Ratio thresholds: one error in RATIO_DEN bits
    localparam int         RATIO_DEN        = 1000;
    localparam int         INNER_MIN_ERRORS = 500;

    // Bits per received byte and per coded symbol pair
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CODE_BITS = 4'h2;

    // Default sizes
    localparam int CNT_W_DEF = 32;
    localparam int BUF_DEPTH = 2;

    // Buffer word layout
    localparam int F_POST_LSB = 0;
    localparam int F_PRE_LSB  = 8;
    localparam int F_UNC_BIT  = 16;
    localparam int F_SOP_BIT  = 17;
    localparam int BUF_W      = 18;

    // Count of set bits in a byte
    function automatic logic [3:0] tsber_pop8(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, b[i]};
        end
        return n;
    endfunction

    // Expected byte of the reference packet at a given position
    function automatic logic [7:0] tsber_ref_byte(input logic [7:0] idx);
        logic [7:0] r;
        case (idx)
            8'h00: r = REF_SYNC;
            8'h01: r = REF_HDR1;
            8'h02: r = REF_HDR2;
            8'h03: r = REF_HDR3;
            default: r = REF_PAYLOAD;
        endcase
        return r;
    endfunction

endpackage

/* File: tsber_fifo.sv */
`timescale 1ns/1ps

module tsber_fifo
    import tsber_pkg::*;
#(
    parameter int W     = BUF_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("tsber_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    // Honest full and empty from the fill count
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = clk_en && in_valid && in_ready;
    assign pop       = clk_en && out_valid && out_ready;

    // Storage write
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    default clocking fifo_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    fill_bound_a: assert property (count <= (AW+1)'(DEPTH))
        else $error("fifo fill count above depth");
    full_stall_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled output word changed");
    fifo_full_c: cover property (!in_ready ##1 pop);
endmodule

/* File: tsber_meas.sv */
// Summary of operation
// R1: Transmit test source uses 2^23-1 sequence
// R2: Reference packet 47 1f ff 10, zeros
// R3: Encoder repeats only the reference packet
// R4: Uncorrectable packet flagged, other bits kept
// R5: In service, compare bits pre/post decode
// R6: Ratio above one per thousand is unreliable
// R7: Uncorrectable packet restarts in-service counts
// R8: Re-encode inner decoder output, same code
// R9: Count mismatches against raw coded stream
// R10: Inner ratio final after several hundred errors
// R11: Ratio is error bits over total bits
// R12: Outer counts advance only when link available
// R13: Post-decode compare with reference, error count
// R14: Post count valid only below one per thousand
// R15: Counters saturate; clear on reset or restart
`timescale 1ns/1ps

module tsber_meas
    import tsber_pkg::*;
#(
    parameter int         CNT_W  = CNT_W_DEF,
    parameter logic [6:0] CODE_G0 = 7'h79,
    parameter logic [6:0] CODE_G1 = 7'h5b
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic             in_service,
    input  wire logic             link_available_window,
    input  wire logic             meas_restart,
    input  wire logic             pkt_valid,
    output logic                  pkt_ready,
    input  wire logic             pkt_sop,
    input  wire logic             pkt_uncorrectable,
    input  wire logic [7:0]       pkt_pre_byte,
    input  wire logic [7:0]       pkt_post_byte,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic                  out_sop,
    output logic                  out_uncorrectable,
    output logic [7:0]            out_byte,
    input  wire logic             inner_valid,
    input  wire logic             inner_dec_bit,
    input  wire logic [1:0]       inner_raw_bits,
    output logic [CNT_W-1:0]      outer_err_count,
    output logic [CNT_W-1:0]      outer_bit_count,
    output logic                  outer_unreliable,
    output logic [CNT_W-1:0]      post_err_count,
    output logic                  post_count_valid,
    output logic [CNT_W-1:0]      inner_err_count,
    output logic [CNT_W-1:0]      inner_bit_count,
    output logic                  inner_final
);
    localparam int SW = CNT_W + 10;

    // Ratio scaling needs room; narrow counters would hide the threshold
    if (CNT_W < 16 || CNT_W > 48) begin : g_bad_width
        $error("tsber_meas: CNT_W must lie between 16 and 48");
    end

    // Saturating add of a small increment
    function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] a,
                                                 input logic [3:0]       inc);
        logic [CNT_W:0] s;
        s = {1'b0, a} + {{(CNT_W-3){1'b0}}, inc};
        return s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
    endfunction

    logic [BUF_W-1:0] buf_in;
    logic [BUF_W-1:0] buf_out;
    logic             fire;
    logic             b_sop;
    logic             b_unc;
    logic [7:0]       b_pre;
    logic [7:0]       b_post;
    logic [7:0]       byte_idx;
    logic [7:0]       cur_idx;
    logic [7:0]       ref_byte;
    logic [3:0]       pre_ref_err;
    logic [3:0]       post_ref_err;
    logic [3:0]       pre_post_err;
    logic [3:0]       outer_inc;
    logic             outer_step;
    logic             outer_clear;
    logic [5:0]       enc_state;
    logic [6:0]       enc_reg;
    logic [1:0]       enc_bits;
    logic [1:0]       code_diff;
    logic [3:0]       inner_inc;
    logic [SW-1:0]    scaled_err;
    logic [SW-1:0]    wide_bits;

    // Two-entry buffer in the packet path; downstream stall holds data
    assign buf_in = {pkt_sop, pkt_uncorrectable, pkt_pre_byte, pkt_post_byte};

    tsber_fifo #(
        .W     (BUF_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .in_valid  (pkt_valid),
        .in_ready  (pkt_ready),
        .in_data   (buf_in),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out)
    );

    // Unpack the buffered byte and forward the decoded stream
    assign b_sop             = buf_out[F_SOP_BIT];
    assign b_unc             = buf_out[F_UNC_BIT];
    assign b_pre             = buf_out[F_PRE_LSB +: 8];
    assign b_post            = buf_out[F_POST_LSB +: 8];
    assign out_sop           = b_sop;
    assign out_uncorrectable = b_unc;
    assign out_byte          = b_post;
    assign fire              = clk_en && out_valid && out_ready;

    // Byte position inside the packet, restarted by start of packet
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            byte_idx <= 8'h00;
        end else if (fire) begin
            if (cur_idx < 8'(PKT_LEN - 1)) begin
                byte_idx <= cur_idx + 8'h01;
            end else begin
                byte_idx <= cur_idx;
            end
        end
    end

    // Expected byte and bit differences for the current byte
    assign cur_idx      = b_sop ? 8'h00 : byte_idx;
    assign ref_byte     = tsber_ref_byte(cur_idx);                  // [R2]
    assign pre_ref_err  = tsber_pop8(b_pre ^ ref_byte);             // [R3]
    assign post_ref_err = tsber_pop8(b_post ^ ref_byte);            // [R13]
    assign pre_post_err = tsber_pop8(b_pre ^ b_post);               // [R5]

    // Outer measurement steering by mode and availability
    assign outer_inc   = in_service ? pre_post_err : pre_ref_err;
    assign outer_step  = fire && link_available_window;              // [R12]
    assign outer_clear = meas_restart ||
                         (outer_step && in_service && b_unc);        // [R7] [R4]

    // Errors before outer decoding, and bits seen
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            outer_err_count <= '0;
            outer_bit_count <= '0;
        end else if (clk_en) begin
            if (outer_clear) begin
                outer_err_count <= '0;                               // [R15]
                outer_bit_count <= '0;
            end else if (outer_step) begin
                outer_err_count <= sat_add(outer_err_count, outer_inc);
                outer_bit_count <= sat_add(outer_bit_count, BYTE_BITS); // [R11]
            end
        end
    end

    // Running error count after outer decoding, out of service only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            post_err_count <= '0;
        end else if (clk_en) begin
            if (meas_restart) begin
                post_err_count <= '0;                                // [R15]
            end else if (outer_step && !in_service) begin
                post_err_count <= sat_add(post_err_count, post_ref_err); // [R13]
            end
        end
    end

    // Ratio against one per thousand without a divider
    assign scaled_err = SW'(outer_err_count) * SW'(RATIO_DEN);
    assign wide_bits  = SW'(outer_bit_count);

    // Ratio flags
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            outer_unreliable <= 1'b0;
            post_count_valid <= 1'b0;
        end else if (clk_en) begin
            outer_unreliable <= in_service && (scaled_err > wide_bits);  // [R6]
            post_count_valid <= (outer_bit_count != '0) &&
                                (scaled_err < wide_bits);                // [R14]
        end
    end

    // Re-encoder with the transmitter's convolutional code
    assign enc_reg     = {inner_dec_bit, enc_state};
    assign enc_bits[0] = ^(enc_reg & CODE_G0);                      // [R8]
    assign enc_bits[1] = ^(enc_reg & CODE_G1);
    assign code_diff   = enc_bits ^ inner_raw_bits;                 // [R9]
    assign inner_inc   = {3'h0, code_diff[0]} + {3'h0, code_diff[1]};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enc_state <= 6'h00;
        end else if (clk_en && inner_valid) begin
            enc_state <= {inner_dec_bit, enc_state[5:1]};           // [R8]
        end
    end

    // Inner error and coded bit counters
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            inner_err_count <= '0;
            inner_bit_count <= '0;
        end else if (clk_en) begin
            if (meas_restart) begin
                inner_err_count <= '0;                               // [R15]
                inner_bit_count <= '0;
            end else if (inner_valid) begin
                inner_err_count <= sat_add(inner_err_count, inner_inc); // [R9]
                inner_bit_count <= sat_add(inner_bit_count, CODE_BITS); // [R11]
            end
        end
    end

    // Inner ratio becomes final once enough errors are counted
    assign inner_final = (inner_err_count >= CNT_W'(INNER_MIN_ERRORS)); // [R10]

    default clocking meas_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    logic [3:0] past_inc;
    assign past_inc = outer_inc;

    restart_clear_a: assert property (                               // [R15]
        clk_en && meas_restart |=> outer_err_count == '0 && outer_bit_count == '0
                                   && post_err_count == '0 && inner_err_count == '0)
        else $error("restart did not clear counters");
    uncorr_clear_a: assert property (                                // [R7]
        clk_en && fire && link_available_window && in_service && b_unc
        |=> outer_err_count == '0 && outer_bit_count == '0)
        else $error("uncorrectable packet did not restart counts");
    pause_hold_a: assert property (                                  // [R12]
        clk_en && !link_available_window && !meas_restart
        |=> $stable(outer_err_count) && $stable(outer_bit_count) && $stable(post_err_count))
        else $error("outer counts moved outside link window");
    cmp_add_a: assert property (                                     // [R5]
        outer_step && !outer_clear && outer_bit_count < CNT_W'(1024)
        && outer_err_count < CNT_W'(1024)
        |=> outer_err_count == $past(outer_err_count) + CNT_W'($past(past_inc))
            && outer_bit_count == $past(outer_bit_count) + CNT_W'(8))
        else $error("outer counts did not advance by byte compare");
    unreliable_a: assert property (                                  // [R6]
        clk_en && in_service && outer_err_count != '0 && outer_bit_count < CNT_W'(1000)
        && outer_bit_count < outer_err_count * CNT_W'(1000) |=> outer_unreliable)
        else $error("high ratio not flagged unreliable");
    post_valid_a: assert property (                                  // [R14]
        post_count_valid && $past(clk_en) |-> $past(scaled_err) < $past(wide_bits))
        else $error("post count valid at high ratio");
    post_match_a: assert property (                                  // [R13]
        outer_step && !in_service && !meas_restart && b_post == ref_byte
        |=> $stable(post_err_count))
        else $error("matching reference byte counted as error");
    inner_step_a: assert property (                                  // [R9]
        clk_en && inner_valid && !meas_restart && inner_bit_count < CNT_W'(1024)
        |=> inner_bit_count == $past(inner_bit_count) + CNT_W'(2)
            && inner_err_count - $past(inner_err_count) <= CNT_W'(2))
        else $error("inner counters did not step by one symbol pair");
    inner_final_a: assert property (                                 // [R10]
        inner_final && !(clk_en && meas_restart) |=> inner_final)
        else $error("inner ratio final dropped without restart");
    inner_restart_a: assert property ( // [R15]
        clk_en && meas_restart |=> !inner_final && inner_bit_count == '0)
        else $error("inner counts survived a restart");
    inner_hold_a: assert property ( // [R9]
        clk_en && !inner_valid && !meas_restart
        |=> $stable(inner_err_count) && $stable(inner_bit_count))
        else $error("inner counters moved without a symbol");

    // Mode guards on the outer and post counts and the unreliable flag
    svc_post_hold_a: assert property ( // [R13]
        clk_en && in_service && !meas_restart |=> $stable(post_err_count))
        else $error("post count moved in service");
    post_step_a: assert property ( // [R13]
        outer_step && !in_service && !meas_restart && post_ref_err != 4'h0
        && post_err_count != '1 |=> post_err_count != $past(post_err_count))
        else $error("reference mismatch not counted");
    oos_unc_keep_a: assert property ( // [R7]
        outer_step && !in_service && b_unc && !meas_restart |=> outer_bit_count != '0)
        else $error("uncorrectable byte cleared counts out of service");
    svc_only_a: assert property ( // [R6]
        outer_unreliable && $past(clk_en) |-> $past(in_service))
        else $error("unreliable flag raised out of service");

    // Restart, index and enable guards
    restart_flags_a: assert property ( // [R15]
        clk_en && meas_restart ##1 clk_en |=> !outer_unreliable && !post_count_valid)
        else $error("ratio flags survived a restart");
    sop_index_a: assert property ( // [R2]
        fire && b_sop |=> byte_idx == 8'h01)
        else $error("start of packet did not restart byte index");
    enable_freeze_a: assert property ( // [R15]
        !clk_en |=> $stable(outer_bit_count) && $stable(post_err_count)
                    && $stable(inner_bit_count) && $stable(post_count_valid))
        else $error("counts moved while clock enable low");

    uncorr_restart_c: cover property (fire && in_service && b_unc ##1 fire);
    inner_final_c: cover property ($rose(inner_final));
    oos_packet_c: cover property (fire && !in_service && cur_idx == 8'(PKT_LEN - 1));
    window_pause_c: cover property (fire && !link_available_window && !in_service);
endmodule

/* File: tsber_far_model.sv */
`timescale 1ns/1ps

// Far side: encoder and decoder chain feeding packet bytes and the inner stream
module tsber_far_model #(
    parameter logic [6:0] G0 = 7'h79,
    parameter logic [6:0] G1 = 7'h5b
) (
    input  wire logic       ref_clk,
    input  wire logic       clk_en,
    input  wire logic       pkt_ready,
    output logic            pkt_valid,
    output logic            pkt_sop,
    output logic            pkt_uncorrectable,
    output logic [7:0]      pkt_pre_byte,
    output logic [7:0]      pkt_post_byte,
    output logic            inner_valid,
    output logic            inner_dec_bit,
    output logic [1:0]      inner_raw_bits,
    output logic            hung
);
    logic [5:0]  enc_st;
    logic [22:0] prbs;

    // Idle outputs at time zero
    initial begin
        {pkt_valid, pkt_sop, pkt_uncorrectable, inner_valid, inner_dec_bit, hung} = '0;
        {pkt_pre_byte, pkt_post_byte, inner_raw_bits} = '0;
        enc_st = '0;
        prbs = '1;
    end

    // Bytes of the fixed reference packet
    function automatic logic [7:0] ref_at(input int i);
        case (i)
            0: return 8'h47;
            1: return 8'h1f;
            2: return 8'hff;
            3: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction

    // Repeats the reference packet; errors only at byte fi, flag at byte ui
    task automatic send_pkt(input int n, input int fi, input logic [7:0] pre_f,
                            input logic [7:0] post_f, input int ui);
        int tries;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            pkt_valid = 1'b1;
            pkt_sop = (i == 0);
            pkt_uncorrectable = (i == ui);
            pkt_pre_byte = ref_at(i) ^ ((i == fi) ? pre_f : 8'h00);
            pkt_post_byte = ref_at(i) ^ ((i == fi) ? post_f : 8'h00);
            tries = 0;
            // Hold the byte until it is seen to be taken at the next edge
            while (!(pkt_ready && clk_en) && tries < 1000) begin
                @(negedge ref_clk);
                tries++;
            end
            if (tries >= 1000)
                hung = 1'b1;
        end
        @(negedge ref_clk);
        pkt_valid = 1'b0;
        pkt_pre_byte = ~pkt_pre_byte;
        pkt_post_byte = ~pkt_post_byte;
    endtask

    // Coded pairs from the decoded bits, flipped from pair ff onward
    task automatic run_inner(input int n, input int ff, input logic [1:0] flip);
        logic [6:0] r;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            r = {prbs[22] ^ prbs[17], enc_st};
            inner_valid = 1'b1;
            inner_dec_bit = r[6];
            inner_raw_bits = {^(r & G1), ^(r & G0)} ^ ((i >= ff) ? flip : 2'b00);
            enc_st = r[6:1];
            prbs = {prbs[21:0], r[6]};
        end
        @(negedge ref_clk);
        inner_valid = 1'b0;
        inner_raw_bits = ~inner_raw_bits;
    endtask
endmodule

/* File: ts_ber_measurement_bench.sv */
`timescale 1ns/1ps

module ts_ber_measurement_bench import tsber_pkg::*;;
    logic        ref_clk, resetn, clk_en, in_service, link_available_window, meas_restart;
    logic        pkt_valid, pkt_ready, pkt_sop, pkt_uncorrectable, out_valid, out_ready;
    logic        out_sop, out_uncorrectable, inner_valid, inner_dec_bit, hung;
    logic        outer_unreliable, post_count_valid, inner_final;
    logic [7:0]  pkt_pre_byte, pkt_post_byte, out_byte;
    logic [1:0]  inner_raw_bits;
    logic [31:0] outer_err_count, outer_bit_count, post_err_count;
    logic [31:0] inner_err_count, inner_bit_count;
    int          fails, num_checks;

    tsber_meas #(.CNT_W(32)) u_tsber_meas (
        .ref_clk, .resetn, .clk_en, .in_service, .link_available_window, .meas_restart,
        .pkt_valid, .pkt_ready, .pkt_sop, .pkt_uncorrectable, .pkt_pre_byte,
        .pkt_post_byte, .out_valid, .out_ready, .out_sop, .out_uncorrectable, .out_byte,
        .inner_valid, .inner_dec_bit, .inner_raw_bits, .outer_err_count,
        .outer_bit_count, .outer_unreliable, .post_err_count, .post_count_valid,
        .inner_err_count, .inner_bit_count, .inner_final
    );

    tsber_far_model u_tsber_far_model (
        .ref_clk, .clk_en, .pkt_ready, .pkt_valid, .pkt_sop, .pkt_uncorrectable,
        .pkt_pre_byte, .pkt_post_byte, .inner_valid, .inner_dec_bit, .inner_raw_bits, .hung
    );

    // 200 MHz clock
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    // Compare helpers, one per kind of result
    task automatic chk_cnt(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic chk_flag(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic chk_outer(input int e, input int b);
        chk_cnt("outer_err_count", e, outer_err_count);
        chk_cnt("outer_bit_count", b, outer_bit_count);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic restart;
        @(negedge ref_clk);
        meas_restart = 1'b1;
        @(negedge ref_clk);
        meas_restart = 1'b0;
    endtask

    // Out of service: two packets, checked after each, against the reference
    task automatic t_out_service;
        in_service = 1'b0;
        restart();
        chk_cnt("outer_bit_count", 0, outer_bit_count);
        u_tsber_far_model.send_pkt(PKT_LEN, 3, 8'h01, 8'h81, -1);
        settle(6);
        chk_outer(1, 8 * PKT_LEN);
        chk_cnt("post_err_count", 2, post_err_count);
        chk_flag("post_count_valid", 1'b1, post_count_valid);
        chk_flag("outer_unreliable", 1'b0, outer_unreliable);
        u_tsber_far_model.send_pkt(PKT_LEN, 0, 8'h07, 8'h00, -1);
        settle(6);
        chk_outer(4, 16 * PKT_LEN);
        chk_cnt("post_err_count", 2, post_err_count);
        chk_flag("post_count_valid", 1'b0, post_count_valid);
    endtask

    // In service: pre/post compare, ratio flag, then an uncorrectable packet
    task automatic t_in_service;
        in_service = 1'b1;
        restart();
        u_tsber_far_model.send_pkt(PKT_LEN, 50, 8'h01, 8'h00, -1);
        settle(6);
        chk_outer(1, 8 * PKT_LEN);
        chk_flag("outer_unreliable", 1'b0, outer_unreliable);
        u_tsber_far_model.send_pkt(PKT_LEN, 187, 8'h0f, 8'h00, -1);
        settle(6);
        chk_outer(5, 16 * PKT_LEN);
        chk_flag("outer_unreliable", 1'b1, outer_unreliable);
        chk_cnt("post_err_count", 0, post_err_count);
        u_tsber_far_model.send_pkt(PKT_LEN, 10, 8'h01, 8'h00, 100);
        settle(6);
        chk_outer(0, 8 * (PKT_LEN - 101));
        chk_flag("outer_unreliable", 1'b0, outer_unreliable);
    endtask

    // Counting pauses while the link is not available
    task automatic t_window;
        in_service = 1'b0;
        restart();
        link_available_window = 1'b0;
        u_tsber_far_model.send_pkt(20, 5, 8'h01, 8'h01, -1);
        settle(6);
        chk_outer(0, 0);
        chk_cnt("post_err_count", 0, post_err_count);
        link_available_window = 1'b1;
        u_tsber_far_model.send_pkt(20, 5, 8'h01, 8'h01, -1);
        settle(6);
        chk_outer(1, 160);
        chk_cnt("post_err_count", 1, post_err_count);
    endtask

    // Receiver stall fills the buffer; clock enable low freezes it
    task automatic t_buffer;
        restart();
        out_ready = 1'b0;
        fork
            u_tsber_far_model.send_pkt(3, -1, 8'h00, 8'h00, 0);
            begin
                settle(8);
                chk_flag("pkt_ready", 1'b0, pkt_ready);
                chk_flag("out_valid", 1'b1, out_valid);
                chk_cnt("out_byte", 32'h47, out_byte);
                chk_flag("out_sop", 1'b1, out_sop);
                chk_flag("out_uncorrectable", 1'b1, out_uncorrectable);
                clk_en = 1'b0;
                out_ready = 1'b1;
                settle(4);
                chk_cnt("outer_bit_count", 0, outer_bit_count);
                clk_en = 1'b1;
            end
        join
        settle(6);
        chk_outer(0, 24);
        chk_flag("out_valid", 1'b0, out_valid);
    endtask

    // Inner path: re-encoded compare and the final threshold at 500 errors
    task automatic t_inner;
        u_tsber_far_model.run_inner(6, 99, 2'b00);
        restart();
        u_tsber_far_model.run_inner(250, 1, 2'b11);
        settle(4);
        chk_cnt("inner_err_count", 498, inner_err_count);
        chk_cnt("inner_bit_count", 500, inner_bit_count);
        chk_flag("inner_final", 1'b0, inner_final);
        u_tsber_far_model.run_inner(1, 0, 2'b01);
        settle(4);
        chk_flag("inner_final", 1'b0, inner_final);
        u_tsber_far_model.run_inner(1, 0, 2'b10);
        settle(4);
        chk_cnt("inner_err_count", 500, inner_err_count);
        chk_flag("inner_final", 1'b1, inner_final);
    endtask

    // Main sequence
    initial begin
        {resetn, in_service, meas_restart} = '0;
        {clk_en, link_available_window, out_ready} = '1;
        fails = 0;
        num_checks = 0;
        settle(5);
        resetn = 1'b1;
        chk_outer(0, 0);
        t_out_service();
        t_in_service();
        t_window();
        t_buffer();
        t_inner();
        if (hung === 1'b1)
            fails++;
        conclude();
    end

    // Hang guard
    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
